// File: inc/scccs_pkg.sv
/*
 * Package of the sensor conversion configuration and status block: register
 * layout, reset values, mode codes, conversion timing tables and state types.
 * Assumes a 100 MHz core clock; times are held as counts of half-millisecond ticks.
 */
package scccs_pkg;

   // Core clock period and the time base of the conversion timer
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 500000;
   localparam logic [15:0] TICK_CYCLES_DEF = 16'(TICK_NS / CLK_PERIOD_NS);

   // Register image after reset
   localparam logic [15:0] CFG_RESET = 16'h0220;
   localparam logic [15:0] TEMP_RESET = 16'h8000;
   localparam logic ALERT_RESET = 1'b1;

   // Mode codes of conv_mode_sel
   localparam logic [1:0] MODE_REPEAT = 2'h0;
   localparam logic [1:0] MODE_PDOWN = 2'h1;
   localparam logic [1:0] MODE_ALIAS = 2'h2;
   localparam logic [1:0] MODE_SINGLE = 2'h3;

   // Averaging depth, divide shift and active time (half-ms ticks), by averaging_count_sel
   localparam logic [3:0][6:0] AVG_COUNT = {7'h40, 7'h20, 7'h08, 7'h01};
   localparam logic [3:0][2:0] AVG_SHIFT = {3'h6, 3'h5, 3'h3, 3'h0};
   localparam logic [3:0][15:0] ACTIVE_TICKS = {16'h07D0, 16'h03E8, 16'h00FA, 16'h001F};

   // Cycle period in half-ms ticks by cycle_period_sel: 15.5 ms up to 16 s
   localparam logic [7:0][15:0] CYCLE_TICKS = {16'h7D00, 16'h3E80, 16'h1F40, 16'h07D0,
                                               16'h03E8, 16'h01F4, 16'h00FA, 16'h001F};

   // Register layout, most significant bit first
   typedef struct packed {
      logic hi_flag;
      logic lo_flag;
      logic done;
      logic busy;
      logic [1:0] conv_mode_sel;
      logic [2:0] cycle_period_sel;
      logic [1:0] averaging_count_sel;
      logic comparator_style_sel;
      logic output_pin_polarity;
      logic pin_source_sel;
      logic [1:0] unused;
   } scccs_cfg_t;

   // Host access request, held by the serial protocol logic around a link clock edge
   typedef struct packed {
      logic wr;
      logic rd_cfg;
      logic rd_temp;
      logic [15:0] wdata;
   } scccs_req_t;

   typedef struct packed {
      logic clk;
      scccs_req_t req;
   } scccs_link_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SAMPLE = 2'h1,
      ST_HOLD = 2'h3
   } scccs_state_t;

   typedef struct packed {
      scccs_link_t sync1;
      scccs_link_t sync2;
      logic link_clk_d;
      scccs_cfg_t cfg;
      scccs_state_t state;
      logic [21:0] acc;
      logic [6:0] nsamp;
      logic pending;
      logic start;
      logic [15:0] presc;
      logic [15:0] ticks;
      logic [15:0] temp;
      logic [15:0] rdata;
      logic alert;
   } scccs_regs_t;

   localparam scccs_regs_t REGS_RESET = '{sync1: '0, sync2: '0, link_clk_d: 1'b0,
                                          cfg: scccs_cfg_t'(CFG_RESET), state: ST_IDLE,
                                          acc: '0, nsamp: '0, pending: 1'b0, start: 1'b0,
                                          presc: '0, ticks: '0, temp: TEMP_RESET,
                                          rdata: CFG_RESET, alert: ALERT_RESET};

endpackage : scccs_pkg

// File: hw/scccs_core.sv
/*
 * Conversion control and status logic of a digital temperature sensor: mode,
 * cycle timing, block averaging, limit flags, done flag and attention pin.
 * Assumes the serial protocol logic holds its request stable around a rising
 * edge of the link clock, and that the converter, limit registers and
 * nonvolatile loader share the core clock.
 */
// Contract
// [RQ1] Alert style: result above high limit sets over-limit flag bit 15.
// [RQ2] Alert style: host read of the register clears the over-limit flag.
// [RQ3] Therm style: above limit sets, below hysteresis clears over-limit flag.
// [RQ4] Alert style: result below low limit sets bit 14; register read clears it.
// [RQ5] Therm style holds the under-limit flag at zero.
// [RQ6] Reading result or configuration register clears done flag bit 13.
// [RQ7] Done flag sets when the result register takes a new value.
// [RQ8] Busy bit 12 mirrors nonvolatile programming or power-up loading.
// [RQ9] Mode bits 11:10: 00 repeat, 01 power-down, 11 single; 10 repeats, reads 00.
// [RQ10] Repeat period is the longer of cycle setting and averaging time.
// [RQ11] Averaging bits 6:5 accumulate a block of results, not a running mean.
// [RQ12] Style bit 4: one selects therm style, zero latched alert style.
// [RQ13] Polarity bit 3: one makes attention output active high, zero low.
// [RQ14] Bit 2 routes done flag, else limit flags, to attention output.
// [RQ15] Writable fields except upper mode bit load from storage; default 0220.
// [RQ16] Upper mode bit never loads from storage; start-up is never single.
// [RQ17] Averaging codes: 1, 8, 32, 64 results; 15.5 ms to 1 s.
// [RQ18] Writes to flag and unused bits do nothing; unused bits read zero.
// [RQ19] Single-shot makes one averaged conversion, then returns to power-down.
module scccs_core #(
   parameter logic [15:0] TICK_CYCLES = scccs_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic link_clk,
   input wire scccs_pkg::scccs_req_t link_req,
   input wire logic sample_valid,
   input wire logic [15:0] sample_value,
   input wire logic [15:0] high_limit,
   input wire logic [15:0] low_limit,
   input wire logic nv_busy,
   input wire logic nv_load,
   input wire logic [15:0] nv_cfg,
   output logic [15:0] cfg_rdata,
   output logic [15:0] temp_result,
   output logic sample_start,
   output logic alert_pin
);
   import scccs_pkg::*;

   scccs_regs_t r;
   scccs_regs_t next_r;

   logic take;
   logic acc_wr;
   logic acc_rd_cfg;
   logic acc_rd_temp;
   logic tick;
   logic upd;
   logic running;
   logic [6:0] count;
   logic [2:0] shift;
   logic [15:0] period;
   logic signed [21:0] sum;
   logic signed [21:0] mean;
   logic signed [15:0] res;
   logic res_high;
   logic res_low;
   scccs_cfg_t wcfg;
   scccs_cfg_t lcfg;

   // Host access taken on a synchronised rising edge of the link clock
   assign take = r.sync2.clk & ~r.link_clk_d;
   assign acc_wr = take & r.sync2.req.wr;
   assign acc_rd_cfg = take & r.sync2.req.rd_cfg;
   assign acc_rd_temp = take & r.sync2.req.rd_temp;
   assign wcfg = scccs_cfg_t'(r.sync2.req.wdata);
   assign lcfg = scccs_cfg_t'(nv_cfg);

   assign tick = (r.presc == TICK_CYCLES - 16'h0001);
   assign count = AVG_COUNT[r.cfg.averaging_count_sel]; // see [RQ17]
   assign shift = AVG_SHIFT[r.cfg.averaging_count_sel]; // see [RQ11]
   // Longer of the selected cycle and the active averaging time
   assign period = (CYCLE_TICKS[r.cfg.cycle_period_sel] > ACTIVE_TICKS[r.cfg.averaging_count_sel])
                   ? CYCLE_TICKS[r.cfg.cycle_period_sel]
                   : ACTIVE_TICKS[r.cfg.averaging_count_sel]; // see [RQ10]
   assign running = (r.cfg.conv_mode_sel != MODE_PDOWN);

   assign sum = $signed(r.acc) + $signed({{6{sample_value[15]}}, sample_value});
   assign mean = sum >>> shift; // see [RQ11]
   assign res = mean[15:0];
   assign upd = (r.state == ST_SAMPLE) & running & r.pending & sample_valid & (r.nsamp + 7'h01 == count);
   assign res_high = res > $signed(high_limit);
   assign res_low = res < $signed(low_limit);

   always_comb
   begin
      next_r = r;
      if (ce)
      begin
         next_r.sync1 = '{clk: link_clk, req: link_req};
         next_r.sync2 = r.sync1;
         next_r.link_clk_d = r.sync2.clk;
         next_r.start = 1'b0;

         // Storage load keeps the upper mode bit clear
         if (nv_load)
         begin
            next_r.cfg.conv_mode_sel = {1'b0, lcfg.conv_mode_sel[0]}; // see [RQ15] [RQ16]
            next_r.cfg.cycle_period_sel = lcfg.cycle_period_sel; // see [RQ15]
            next_r.cfg.averaging_count_sel = lcfg.averaging_count_sel;
            next_r.cfg.comparator_style_sel = lcfg.comparator_style_sel;
            next_r.cfg.output_pin_polarity = lcfg.output_pin_polarity;
            next_r.cfg.pin_source_sel = lcfg.pin_source_sel;
         end
         // Host write touches writable fields only
         if (acc_wr)
         begin
            next_r.cfg.conv_mode_sel = (wcfg.conv_mode_sel == MODE_ALIAS) ? MODE_REPEAT
                                       : wcfg.conv_mode_sel; // see [RQ9]
            next_r.cfg.cycle_period_sel = wcfg.cycle_period_sel; // see [RQ18]
            next_r.cfg.averaging_count_sel = wcfg.averaging_count_sel;
            next_r.cfg.comparator_style_sel = wcfg.comparator_style_sel; // see [RQ12]
            next_r.cfg.output_pin_polarity = wcfg.output_pin_polarity;
            next_r.cfg.pin_source_sel = wcfg.pin_source_sel;
         end

         // Read snapshot, then read side effects
         if (acc_rd_cfg)
         begin
            next_r.rdata = {r.cfg.hi_flag, r.cfg.lo_flag, r.cfg.done, nv_busy,
                            r.cfg.conv_mode_sel, r.cfg.cycle_period_sel, r.cfg.averaging_count_sel,
                            r.cfg.comparator_style_sel, r.cfg.output_pin_polarity,
                            r.cfg.pin_source_sel, 2'h0}; // see [RQ8] [RQ18]
            if (!r.cfg.comparator_style_sel)
            begin
               next_r.cfg.hi_flag = 1'b0; // see [RQ2]
               next_r.cfg.lo_flag = 1'b0; // see [RQ4]
            end
         end
         if (acc_rd_cfg || acc_rd_temp)
         begin
            next_r.cfg.done = 1'b0; // see [RQ6]
         end

         // Conversion timer
         next_r.presc = tick ? 16'h0000 : r.presc + 16'h0001;
         if (tick && r.ticks != 16'hFFFF)
         begin
            next_r.ticks = r.ticks + 16'h0001;
         end

         case (r.state)
            ST_IDLE:
            begin
               if (running)
               begin
                  next_r.state = ST_SAMPLE;
                  next_r.acc = '0;
                  next_r.nsamp = '0;
                  next_r.pending = 1'b0;
                  next_r.presc = '0;
                  next_r.ticks = '0;
               end
            end
            ST_SAMPLE:
            begin
               if (!running)
               begin
                  next_r.state = ST_IDLE;
               end
               else if (!r.pending)
               begin
                  next_r.start = 1'b1;
                  next_r.pending = 1'b1;
               end
               else if (sample_valid)
               begin
                  next_r.pending = 1'b0;
                  next_r.acc = sum; // see [RQ11]
                  next_r.nsamp = r.nsamp + 7'h01;
                  if (upd)
                  begin
                     next_r.temp = res;
                     next_r.cfg.done = 1'b1; // see [RQ7]
                     if (r.cfg.comparator_style_sel)
                     begin
                        if (res_high)
                        begin
                           next_r.cfg.hi_flag = 1'b1; // see [RQ3]
                        end
                        else if (res_low)
                        begin
                           next_r.cfg.hi_flag = 1'b0; // see [RQ3]
                        end
                     end
                     else
                     begin
                        if (res_high)
                        begin
                           next_r.cfg.hi_flag = 1'b1; // see [RQ1]
                        end
                        if (res_low)
                        begin
                           next_r.cfg.lo_flag = 1'b1; // see [RQ4]
                        end
                     end
                     if (r.cfg.conv_mode_sel == MODE_SINGLE)
                     begin
                        next_r.cfg.conv_mode_sel = MODE_PDOWN; // see [RQ19]
                        next_r.state = ST_IDLE;
                     end
                     else
                     begin
                        next_r.state = ST_HOLD;
                     end
                  end
               end
            end
            ST_HOLD:
            begin
               if (!running)
               begin
                  next_r.state = ST_IDLE;
               end
               else if (r.ticks >= period)
               begin
                  next_r.state = ST_SAMPLE; // see [RQ10]
                  next_r.acc = '0;
                  next_r.nsamp = '0;
                  next_r.pending = 1'b0;
                  next_r.presc = '0;
                  next_r.ticks = '0;
               end
            end
            default:
            begin
               next_r.state = ST_IDLE;
            end
         endcase

         if (next_r.cfg.comparator_style_sel)
         begin
            next_r.cfg.lo_flag = 1'b0; // see [RQ5]
         end
         next_r.cfg.busy = 1'b0;
         next_r.cfg.unused = 2'h0;

         // Attention pin from the chosen source at the chosen polarity
         next_r.alert = (next_r.cfg.pin_source_sel ? next_r.cfg.done
                         : (next_r.cfg.hi_flag | next_r.cfg.lo_flag))
                        ~^ next_r.cfg.output_pin_polarity; // see [RQ13] [RQ14]
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         r <= REGS_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign cfg_rdata = r.rdata;
   assign temp_result = r.temp;
   assign sample_start = r.start;
   assign alert_pin = r.alert;

   default clocking dflt_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_HI_SET: assert property (ce && upd && !r.cfg.comparator_style_sel && res_high |=> r.cfg.hi_flag) // see [RQ1]
      else $error("over-limit flag not set by high result");
   AST_RD_CLEAR: assert property (ce && acc_rd_cfg && !upd && !r.cfg.comparator_style_sel
                                  |=> !r.cfg.hi_flag && !r.cfg.lo_flag) // see [RQ2]
      else $error("alert flags not cleared by register read");
   AST_THERM_CLR: assert property (ce && upd && r.cfg.comparator_style_sel && !res_high && res_low
                                   |=> !r.cfg.hi_flag) // see [RQ3]
      else $error("therm flag not cleared below hysteresis");
   AST_THERM_HOLD: assert property (ce && r.cfg.comparator_style_sel && !upd && !acc_wr && !nv_load
                                    |=> r.cfg.hi_flag == $past(r.cfg.hi_flag)) // see [RQ3]
      else $error("therm flag changed without a result");
   AST_LO_SET: assert property (ce && upd && !r.cfg.comparator_style_sel && res_low |=> r.cfg.lo_flag) // see [RQ4]
      else $error("under-limit flag not set by low result");
   AST_LO_THERM: assert property (r.cfg.comparator_style_sel |-> !r.cfg.lo_flag) // see [RQ5]
      else $error("under-limit flag set in therm style");
   AST_DONE_CLR: assert property (ce && (acc_rd_cfg || acc_rd_temp) && !upd |=> !r.cfg.done) // see [RQ6]
      else $error("done flag survived a read");
   AST_DONE_SET: assert property (ce && upd |=> r.cfg.done && temp_result == $past(res)) // see [RQ7]
      else $error("done flag or result not updated");
   AST_BUSY: assert property (ce && acc_rd_cfg |=> cfg_rdata[12] == $past(nv_busy) && cfg_rdata[1:0] == 2'h0) // see [RQ8]
      else $error("busy mirror or unused bits wrong");
   AST_MODE_ALIAS: assert property (ce && acc_wr && !upd && wcfg.conv_mode_sel == MODE_ALIAS
                                    |=> r.cfg.conv_mode_sel == MODE_REPEAT) // see [RQ9]
      else $error("mode code 10 not folded to 00");
   AST_PERIOD: assert property (ce && r.state == ST_HOLD && running && r.ticks >= period
                                |=> r.state == ST_SAMPLE && r.ticks == 16'h0000) // see [RQ10]
      else $error("conversion cycle did not restart at period");
   AST_EARLY: assert property (ce && r.state == ST_HOLD && r.ticks < period |=> r.state != ST_SAMPLE) // see [RQ10]
      else $error("conversion restarted before period");
   AST_PIN: assert property (alert_pin == ((r.cfg.pin_source_sel ? r.cfg.done : (r.cfg.hi_flag | r.cfg.lo_flag))
                             ~^ r.cfg.output_pin_polarity)) // see [RQ13]
      else $error("attention pin level wrong");
   AST_NV_LOAD: assert property (ce && nv_load && !acc_wr |=> !r.cfg.conv_mode_sel[1]) // see [RQ16]
      else $error("storage load set upper mode bit");
   AST_SINGLE: assert property (ce && upd && r.cfg.conv_mode_sel == MODE_SINGLE
                                |=> r.cfg.conv_mode_sel == MODE_PDOWN && r.state == ST_IDLE) // see [RQ19]
      else $error("single shot did not return to power-down");

   // Sequencing and field guards
   AST_START_ONE: assert property (ce && sample_start |=> !sample_start) // see [RQ11]
      else $error("sample request longer than one cycle");
   AST_START_STATE: assert property (sample_start |-> r.state == ST_SAMPLE) // see [RQ19]
      else $error("sample request outside sampling state");
   AST_UNUSED_ZERO: assert property (r.cfg.unused == 2'h0 && !r.cfg.busy) // see [RQ18]
      else $error("unused or busy bits stored");
   AST_WR_RO: assert property (ce && acc_wr && !acc_rd_cfg && !upd && !nv_load && !wcfg.comparator_style_sel
                               |=> r.cfg.hi_flag == $past(r.cfg.hi_flag) && r.cfg.lo_flag == $past(r.cfg.lo_flag)) // see [RQ18]
      else $error("host write changed a flag bit");
   AST_NV_FIELDS: assert property (ce && nv_load && !acc_wr |=> r.cfg.cycle_period_sel == $past(lcfg.cycle_period_sel)
                                   && r.cfg.averaging_count_sel == $past(lcfg.averaging_count_sel)) // see [RQ15]
      else $error("storage load did not set fields");
   AST_PDOWN_IDLE: assert property (ce && r.cfg.conv_mode_sel == MODE_PDOWN && r.state != ST_IDLE
                                    |=> r.state == ST_IDLE) // see [RQ9]
      else $error("power-down did not stop conversions");
   AST_TEMP_STABLE: assert property (ce && !upd |=> temp_result == $past(temp_result)) // see [RQ7]
      else $error("result changed without a finished conversion");
   AST_RDATA_HOLD: assert property (ce && !acc_rd_cfg |=> cfg_rdata == $past(cfg_rdata)) // see [RQ8]
      else $error("read snapshot changed without a read");

   COV_SINGLE: cover property (ce && upd && r.cfg.conv_mode_sel == MODE_SINGLE);
   COV_PERIOD: cover property (ce && r.state == ST_HOLD && r.ticks >= period);
   COV_THERM_CLEAR: cover property (ce && upd && r.cfg.comparator_style_sel && r.cfg.hi_flag && res_low);
   COV_READ_SET: cover property (ce && upd && acc_rd_cfg && res_high);
   COV_ALIAS: cover property (ce && acc_wr && wcfg.conv_mode_sel == MODE_ALIAS);

endmodule : scccs_core

// File: tb/scccs_host.sv
/*
 * Host controller model for the conversion control block: presents one
 * register access per link clock pulse, link clock still between frames.
 * Assumes the block samples link_clk and link_req with its own core clock.
 */
module scccs_host (
   input wire logic clk,
   output scccs_pkg::scccs_req_t link_req,
   output logic link_clk
);
   import scccs_pkg::*;

   timeunit 1ns;
   timeprecision 1ps;

   event rd_done;

   initial
   begin
      link_clk = 1'b0;
      link_req = '0;
   end

   // One frame: request set up, link clock pulse of 80 ns, request released
   task automatic access(input logic wr, input logic rd_cfg, input logic rd_temp, input logic [15:0] wdata);
      @(posedge clk);
      link_req <= '{wr: wr, rd_cfg: rd_cfg, rd_temp: rd_temp, wdata: wdata};
      repeat (8) @(posedge clk);
      link_clk <= 1'b1;
      repeat (8) @(posedge clk);
      link_clk <= 1'b0;
      // Released request shows a changing pattern
      link_req <= ~link_req;
      if (rd_cfg)
      begin
         -> rd_done;
      end
   endtask : access

endmodule : scccs_host

// File: tb/testbench.sv
/*
 * Self-checking bench of the conversion control block: host model on the
 * register port, converter model on the sample port, queued expectations.
 * Assumes the design runs with TICK_CYCLES set to 4.
 */
module testbench;
   import scccs_pkg::*;

   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic link_clk;
   scccs_req_t link_req;
   logic sample_valid = 1'b0;
   logic [15:0] sample_value = '0;
   logic [15:0] high_limit = 16'h7000;
   logic [15:0] low_limit = 16'h0100;
   logic nv_busy = 1'b0;
   logic nv_load = 1'b0;
   logic [15:0] nv_cfg = '0;
   logic [15:0] cfg_rdata;
   logic [15:0] temp_result;
   logic sample_start;
   logic alert_pin;
   int bad_count = 0;
   int check_count = 0;
   logic [15:0] exp_cfg[$];
   logic [15:0] exp_temp[$];
   logic [15:0] last_temp = 16'h8000;
   int n_exp = 1, cnt = 0, sum = 0, lo_val = 0, span = 0, dly = 0, res_due = 0;
   logic [2:0] sh = '0;
   logic conv_en = 1'b0;
   time t_prev = 0, t_last = 0;

   scccs_core #(.TICK_CYCLES(16'h0004)) dut_u (.clk(clk), .rst(rst), .ce(1'b1), .link_clk(link_clk),
      .link_req(link_req), .sample_valid(sample_valid), .sample_value(sample_value), .high_limit(high_limit),
      .low_limit(low_limit), .nv_busy(nv_busy), .nv_load(nv_load), .nv_cfg(nv_cfg), .cfg_rdata(cfg_rdata),
      .temp_result(temp_result), .sample_start(sample_start), .alert_pin(alert_pin));

   scccs_host host_u (.clk(clk), .link_req(link_req), .link_clk(link_clk));

   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic wr_cfg(input logic [15:0] d);
      host_u.access(1'b1, 1'b0, 1'b0, d);
   endtask : wr_cfg

   task automatic rd_cfg(input logic [15:0] exp);
      exp_cfg.push_back(exp);
      host_u.access(1'b0, 1'b1, 1'b0, 16'h0000);
   endtask : rd_cfg

   task automatic wait_alert(input logic v);
      int i;
      for (i = 0; i < 400 && alert_pin !== v; i++)
         @(negedge clk);
      check("alert_pin", 16'(v), 16'(alert_pin));
   endtask : wait_alert

   task automatic shot(input int n, input int s, input int lo, input int sp, input logic [15:0] mode_word);
      n_exp = n;
      sh = 3'(s);
      lo_val = lo;
      span = sp;
      cnt = 0;
      sum = 0;
      conv_en = 1'b1;
      wr_cfg(mode_word);
   endtask : shot

   // Converter: once conv_en is set, answers each sample request two cycles later
   always @(posedge clk)
   begin : conv_model
      logic [15:0] v;
      sample_valid <= (dly == 1);
      if (dly == 1)
      begin
         v = 16'(lo_val + $urandom_range(span, 0));
         sample_value <= v;
         sum += $signed(v);
         cnt++;
         if (cnt == n_exp)
         begin
            exp_temp.push_back(16'(sum >>> sh));
            res_due = 2;
            cnt = 0;
            sum = 0;
         end
      end
      if (dly > 0)
         dly = dly - 1;
      else if (sample_start === 1'b1 && conv_en)
      begin
         dly = 2;
         t_prev = t_last;
         t_last = $time;
      end
   end

   always @(host_u.rd_done)
   begin
      if (exp_cfg.size() == 0)
         check("cfg_queue", 16'h0001, 16'h0000);
      else
         check("cfg_rdata", exp_cfg.pop_front(), cfg_rdata);
   end

   // Result due one edge after the last sample; repeated values are still checked
   always @(negedge clk)
   begin
      if (res_due > 0)
         res_due--;
      if (rst === 1'b0 && res_due == 0 && exp_temp.size() > 0)
      begin
         last_temp = temp_result;
         check("temp_result", exp_temp.pop_front(), temp_result);
      end
      else if (rst === 1'b0 && temp_result !== last_temp)
      begin
         last_temp = temp_result;
         check("temp_queue", 16'h0001, 16'h0000);
      end
   end

   initial
   begin
      #200us;
      bad_count++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(67262));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_cfg(16'h0220);
      wr_cfg(16'h0420);
      rd_cfg(16'h0420);
      wr_cfg(16'hFB9F);
      rd_cfg(16'h039C);
      check("alert_pin", 16'h0000, 16'(alert_pin));
      @(posedge clk);
      nv_busy <= 1'b1;
      rd_cfg(16'h139C);
      @(posedge clk);
      nv_busy <= 1'b0;
      nv_cfg <= 16'hFFFF;
      nv_load <= 1'b1;
      @(posedge clk);
      nv_load <= 1'b0;
      rd_cfg(16'h07FC);
      shot(1, 0, 16'h7100, 16'h00FF, 16'h0C00);
      wait_alert(1'b0);
      rd_cfg(16'hA400);
      check("alert_pin", 16'h0001, 16'(alert_pin));
      rd_cfg(16'h0400);
      shot(8, 3, 16'h0000, 16'h00FF, 16'h0C20);
      wait_alert(1'b0);
      rd_cfg(16'h6420);
      shot(1, 0, 16'h7100, 16'h00FF, 16'h0C10);
      wait_alert(1'b0);
      rd_cfg(16'hA410);
      rd_cfg(16'h8410);
      check("alert_pin", 16'h0000, 16'(alert_pin));
      shot(1, 0, 16'h0000, 16'h00FF, 16'h0C1C);
      wait_alert(1'b1);
      host_u.access(1'b0, 1'b0, 1'b1, 16'h0000);
      check("alert_pin", 16'h0000, 16'(alert_pin));
      rd_cfg(16'h041C);
      high_limit <= 16'h7FFF;
      low_limit <= 16'h8000;
      shot(1, 0, 16'h0200, 16'h00FF, 16'h0000);
      repeat (400) @(posedge clk);
      check("period_ok", 16'h0001, 16'((t_last - t_prev) >= 1240 && (t_last - t_prev) <= 1270));
      report_and_stop();
   end

endmodule : testbench
